// ==== fcms_defines.vh ====
`ifndef FCMS_DEFINES_VH
`define FCMS_DEFINES_VH

// Register indices (printed offsets not multiples of four)
`define FCMS_IDX_FUNC_SEL      8'h12
`define FCMS_IDX_CLKGEN_DATA   8'h13
`define FCMS_IDX_STATUS        8'h14
`define FCMS_ADDR_FUNC_SEL     12'h048
`define FCMS_ADDR_CLKGEN_DATA  12'h04c
`define FCMS_ADDR_STATUS       12'h050

// Reset values
`define FCMS_FUNC_SEL_RST      4'h0
`define FCMS_CLKGEN_DATA_RST   8'h00

// Function select encodings (upper two bits)
`define FCMS_FN_CLKGEN         2'h0
`define FCMS_FN_FM_IF          2'h1
`define FCMS_FN_AM_IF          2'h2
`define FCMS_FN_EXT_GATE       2'h3

// Clock generator data register fields
`define FCMS_CGD_VALUE_HI      7
`define FCMS_CGD_VALUE_LO      2
`define FCMS_CGD_MODE_BIT      0

// Timing: base clock 18 kHz from 20 MHz system clock
`define FCMS_SYS_CLK_HZ        20000000
`define FCMS_BASE_CLK_HZ       18000
`define FCMS_BASE_DIV          (`FCMS_SYS_CLK_HZ / `FCMS_BASE_CLK_HZ)
// Last divider count before the base tick (divide by 1111)
`define FCMS_BASE_DIV_LAST     11'h456
`define FCMS_DUTY_PERIOD       7'h43
`define FCMS_VALUE_OFFSET      7'h02

`endif

// ==== fcms_clkgen_core.v ====
`include "fcms_defines.vh"

// Shared 7-bit counter: clock generator when selected, else six bits are the
// upper bits of the intermediate-frequency counter.
module fcms_clkgen_core
(
	input  wire       i_clk,
	input  wire       i_rst_b,
	input  wire       i_base_tick,
	input  wire       i_clkgen_active,
	input  wire       i_square_mode,
	input  wire [5:0] i_value,
	input  wire       i_if_carry,
	output reg  [5:0] o_count,
	output reg        o_wave
);

	reg  [6:0] cnt_r;
	wire [6:0] value_ext;
	wire [6:0] duty_limit;
	wire [6:0] sq_reload;

	assign value_ext  = {1'b0, i_value};
	assign duty_limit = value_ext + `FCMS_VALUE_OFFSET;
	// Reload for value plus two base ticks per half period
	assign sq_reload  = value_ext + `FCMS_VALUE_OFFSET - 7'h01;

	// One counter serves both functions so they can never run together
	always @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_r   <= 7'h00;
			o_count <= 6'h00;
			o_wave  <= 1'b0;
		end
		else if (!i_clkgen_active)
		begin
			// IF counting mode: upper six bits count carries
			if (i_if_carry)
				cnt_r <= {1'b0, cnt_r[5:0] + 6'h01};
			o_wave  <= 1'b0;
			o_count <= cnt_r[5:0];
		end
		else if (i_base_tick)
		begin
			o_count <= cnt_r[5:0];
			if (i_square_mode)
			begin
				// Count down; each zero toggles a divide-by-two stage
				if (cnt_r == 7'h00)
				begin
					cnt_r  <= sq_reload;
					o_wave <= ~o_wave;
				end
				else
					cnt_r <= cnt_r - 7'h01;
			end
			else
			begin
				// 67-count period; high while limit exceeds count
				if (cnt_r >= `FCMS_DUTY_PERIOD - 7'h01)
					cnt_r <= 7'h00;
				else
					cnt_r <= cnt_r + 7'h01;
				o_wave <= (duty_limit > cnt_r);
			end
		end
	end

endmodule // fcms_clkgen_core

// ==== fcms_mode_select.v ====
// Contract
// - Upper two mode bits pick clock generator, FM, AM or external gate.
// - Lower two bits pick gate time or reference frequency.
// - Counter and clock generator never run together.
// - Generator counter is the upper six bits of the IF counter.
// - Generator data register holds mode and duty or frequency value.
// - An 18 kHz base clock drives the generator counter.
// - Duty mode high while value plus two exceeds count, 67 period.
// - Square mode toggles at each zero, reload value plus two (code reloads value plus one, so each half period is value plus two ticks).
//
// The implementer's own choice: the APB register port.
`include "fcms_defines.vh"

module fcms_mode_select
(
	input  wire        I_SYS_CLK,
	input  wire        I_RST_B,
	input  wire        I_CLK_STOP_RST,
	input  wire        I_CE_RST,
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [11:0] I_PADDR,
	input  wire [31:0] I_PWDATA,
	input  wire        I_PIN_ROUTE,
	input  wire        I_IF_CARRY,
	output reg  [31:0] O_PRDATA,
	output wire        O_PREADY,
	output wire        O_PSLVERR,
	output wire [1:0]  O_FUNCTION,
	output wire [1:0]  O_GATE_TIME,
	output wire        O_FM_IF,
	output wire        O_AM_IF,
	output wire        O_EXT_GATE,
	output wire        O_CLKGEN_ACTIVE,
	output reg         O_CLKGEN_PIN,
	output reg         O_CLKGEN_PIN_OE
);

	reg  [3:0]  func_sel_r;
	reg  [7:0]  clkgen_data_r;
	reg  [10:0] div_r;
	reg         base_tick_r;
	reg         stop_s1_r;
	reg         stop_s2_r;
	reg         ce_s1_r;
	reg         ce_s2_r;
	reg         route_s1_r;
	reg         route_s2_r;
	wire        wr_en;
	wire        rd_en;
	wire        clkgen_active;
	wire [5:0]  shared_count;
	wire        wave;

	// Decode a word-aligned register address
	function hit;
		input [11:0] addr;
		input [11:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE;
	assign rd_en     = I_PSEL & ~I_PWRITE;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = 1'b0; // Unmapped reads zero, writes ignored

	// Synchronise external reset requests and the pin route control
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			stop_s1_r  <= 1'b0;
			stop_s2_r  <= 1'b0;
			ce_s1_r    <= 1'b0;
			ce_s2_r    <= 1'b0;
			route_s1_r <= 1'b0;
			route_s2_r <= 1'b0;
		end
		else
		begin
			stop_s1_r  <= I_CLK_STOP_RST;
			stop_s2_r  <= stop_s1_r;
			ce_s1_r    <= I_CE_RST;
			ce_s2_r    <= ce_s1_r;
			route_s1_r <= I_PIN_ROUTE;
			route_s2_r <= route_s1_r;
		end
	end

	// Register writes; power-on and clock-stop clear, CE reset does not
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			func_sel_r    <= `FCMS_FUNC_SEL_RST;
			clkgen_data_r <= `FCMS_CLKGEN_DATA_RST;
		end
		else if (stop_s2_r)
		begin
			func_sel_r    <= `FCMS_FUNC_SEL_RST;
			clkgen_data_r <= `FCMS_CLKGEN_DATA_RST;
		end
		else if (wr_en)
		begin
			// CE reset only blocks nothing here: contents retained
			if (hit(I_PADDR, `FCMS_ADDR_FUNC_SEL))
				func_sel_r <= I_PWDATA[3:0];
			if (hit(I_PADDR, `FCMS_ADDR_CLKGEN_DATA))
				clkgen_data_r <= I_PWDATA[7:0];
		end
	end

	// Read mux, taken in the setup cycle so data stands in access phase
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			O_PRDATA <= 32'h00000000;
		else if (rd_en && !I_PENABLE)
		begin
			if (hit(I_PADDR, `FCMS_ADDR_FUNC_SEL))
				O_PRDATA <= {28'h0000000, func_sel_r};
			else if (hit(I_PADDR, `FCMS_ADDR_CLKGEN_DATA))
				O_PRDATA <= {24'h000000, clkgen_data_r};
			else if (hit(I_PADDR, `FCMS_ADDR_STATUS))
				O_PRDATA <= {22'h000000, ce_s2_r, wave, shared_count,
					clkgen_active, route_s2_r};
			else
				O_PRDATA <= 32'h00000000;
		end
	end

	// Divide the system clock to the 18 kHz base tick
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			div_r       <= 11'h000;
			base_tick_r <= 1'b0;
		end
		else if (div_r == `FCMS_BASE_DIV_LAST)
		begin
			div_r       <= 11'h000;
			base_tick_r <= 1'b1;
		end
		else
		begin
			div_r       <= div_r + 11'h001;
			base_tick_r <= 1'b0;
		end
	end

	// Exactly one function active, chosen by the upper bits
	assign O_FUNCTION      = func_sel_r[3:2];
	assign O_GATE_TIME     = func_sel_r[1:0];
	assign clkgen_active   = (func_sel_r[3:2] == `FCMS_FN_CLKGEN);
	assign O_CLKGEN_ACTIVE = clkgen_active;
	assign O_FM_IF    = (func_sel_r[3:2] == `FCMS_FN_FM_IF);
	assign O_AM_IF    = (func_sel_r[3:2] == `FCMS_FN_AM_IF);
	assign O_EXT_GATE = (func_sel_r[3:2] == `FCMS_FN_EXT_GATE);

	fcms_clkgen_core u_core
	(
		.i_clk           (I_SYS_CLK),
		.i_rst_b         (I_RST_B),
		.i_base_tick     (base_tick_r),
		.i_clkgen_active (clkgen_active),
		.i_square_mode   (clkgen_data_r[`FCMS_CGD_MODE_BIT]),
		.i_value         (clkgen_data_r[`FCMS_CGD_VALUE_HI:`FCMS_CGD_VALUE_LO]),
		.i_if_carry      (I_IF_CARRY),
		.o_count         (shared_count),
		.o_wave          (wave)
	);

	// Drive the pin only when routed and generator selected
	always @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			O_CLKGEN_PIN    <= 1'b0;
			O_CLKGEN_PIN_OE <= 1'b0;
		end
		else
		begin
			O_CLKGEN_PIN_OE <= route_s2_r & clkgen_active;
			O_CLKGEN_PIN    <= wave & route_s2_r & clkgen_active;
		end
	end

endmodule // fcms_mode_select

// ==== fcms_mode_select_sva.sv ====
`include "fcms_defines.vh"
module fcms_mode_select_sva
(
	input wire        I_SYS_CLK,
	input wire        I_RST_B,
	input wire        I_CLK_STOP_RST,
	input wire        I_PSEL,
	input wire        I_PENABLE,
	input wire        I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire [31:0] O_PRDATA,
	input wire [1:0]  O_FUNCTION,
	input wire [1:0]  O_GATE_TIME,
	input wire        O_FM_IF,
	input wire        O_AM_IF,
	input wire        O_EXT_GATE,
	input wire        O_CLKGEN_ACTIVE,
	input wire        O_CLKGEN_PIN_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_B);
	// Access phase aimed at the mode register
	wire acc = I_PSEL && I_PENABLE && I_PADDR == `FCMS_ADDR_FUNC_SEL;
	wr_func_a: assert property (acc && I_PWRITE |=>
		O_FUNCTION == $past(I_PWDATA[3:2])) else $error("function lost");
	wr_gate_a: assert property (acc && I_PWRITE |=>
		O_GATE_TIME == $past(I_PWDATA[1:0])) else $error("gate lost");
	decode_a: assert property (O_FM_IF == (O_FUNCTION == 2'h1) &&
		O_AM_IF == (O_FUNCTION == 2'h2) && O_EXT_GATE == (O_FUNCTION == 2'h3))
		else $error("bad decode");
	one_func_a: assert property (
		$onehot({O_FM_IF, O_AM_IF, O_EXT_GATE, O_CLKGEN_ACTIVE}))
		else $error("functions overlap");
	rd_mode_a: assert property (acc && !I_PWRITE |->
		O_PRDATA == {28'h0, O_FUNCTION, O_GATE_TIME}) else $error("bad read");
	oe_idle_a: assert property (!O_CLKGEN_ACTIVE [*4] |->
		!O_CLKGEN_PIN_OE) else $error("pin driven while counting");
	stop_clr_a: assert property (I_CLK_STOP_RST [*4] |->
		{O_FUNCTION, O_GATE_TIME} == 4'h0) else $error("stop not cleared");
	por_clr_a: assert property ($rose(I_RST_B) |->
		{O_FUNCTION, O_GATE_TIME} == 4'h0) else $error("reset not cleared");
endmodule // fcms_mode_select_sva

bind fcms_mode_select fcms_mode_select_sva u_sva (.*);

// ==== fcms_tuner_model.sv ====
module fcms_tuner_model
(
	input  wire       i_clk,
	input  wire       i_route_req,
	input  wire [1:0] i_function,
	output logic      o_pin_route,
	output logic      o_if_carry
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] div_r = 4'h0;
	// Route granted only once counting is off, so the pin never contends
	always @(posedge i_clk)
	begin
		o_pin_route <= i_route_req && (i_function == 2'h0 || o_pin_route);
		div_r <= div_r + 4'h1;
		o_if_carry <= i_function != 2'h0 && div_r == 4'hf;
	end
endmodule // fcms_tuner_model

// ==== tb_freq_counter_clkgen_mode_select.sv ====
`include "fcms_defines.vh"
module tb_freq_counter_clkgen_mode_select;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_SYS_CLK = 1'b0, I_RST_B = 1'b0, I_CLK_STOP_RST = 1'b0;
	logic I_CE_RST = 1'b0, I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
	logic [11:0] I_PADDR = 12'h0;
	logic [31:0] I_PWDATA = 32'h0, lfsr = 32'h54bd, exp_q[$];
	logic route_req = 1'b0;
	wire I_PIN_ROUTE, I_IF_CARRY, O_PREADY, O_PSLVERR, O_FM_IF, O_AM_IF;
	wire O_EXT_GATE, O_CLKGEN_ACTIVE, O_CLKGEN_PIN, O_CLKGEN_PIN_OE;
	wire [31:0] O_PRDATA;
	wire [1:0] O_FUNCTION, O_GATE_TIME;
	int mismatches = 0, n_checks = 0, n;
	localparam logic [11:0] MA = `FCMS_ADDR_FUNC_SEL;
	localparam logic [11:0] GA = `FCMS_ADDR_CLKGEN_DATA;

	always #25 I_SYS_CLK = ~I_SYS_CLK;
	fcms_mode_select DUT (.*);
	fcms_tuner_model u_far (.i_clk(I_SYS_CLK), .i_route_req(route_req),
		.i_function(O_FUNCTION), .o_pin_route(I_PIN_ROUTE),
		.o_if_carry(I_IF_CARRY));

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string s, logic [31:0] seen, logic [31:0] want);
		n_checks++;
		if (seen !== want)
		begin
			mismatches++;
			$display("BAD %s exp %h seen %h", s, want, seen);
		end
	endtask
	// Pseudo-random words for stimulus
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// One APB transfer; an idle edge follows so strobes never double up
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		int k = 0;
		I_PSEL <= 1'b1;
		I_PWRITE <= wr;
		I_PADDR <= a;
		I_PWDATA <= d;
		@(posedge I_SYS_CLK);
		I_PENABLE <= 1'b1;
		do
			@(posedge I_SYS_CLK);
		while (O_PREADY !== 1'b1 && ++k < 50);
		if (k == 50)
		begin
			chk("pready", k, 0);
			end_of_test();
		end
		I_PSEL <= 1'b0;
		I_PENABLE <= 1'b0;
		@(posedge I_SYS_CLK);
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// Counts edges until the pin (or its enable) shows v; the bound lets a
	// leftover shared count of up to 67 base ticks drain first
	task automatic wait_pin(logic oe, logic v);
		for (n = 0; (oe ? O_CLKGEN_PIN_OE : O_CLKGEN_PIN) !== v; n++)
		begin
			@(posedge I_SYS_CLK);
			if (n >= 76000)
			begin
				chk("pin wait", 1, 0);
				end_of_test();
			end
		end
	endtask
	// Completed reads are matched against the oldest expectation
	always @(posedge I_SYS_CLK)
		if (I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE)
			chk("prdata", O_PRDATA, exp_q.pop_front());

	initial
	begin
		repeat (12) @(posedge I_SYS_CLK);
		I_RST_B <= 1'b1;
		@(posedge I_SYS_CLK);
		rd(MA, 32'h0);
		for (int v = 0; v < 16; v++)
		begin
			apb(1'b1, MA, v);
			chk("func", O_FUNCTION, v[3:2]);
			chk("gate", O_GATE_TIME, v[1:0]);
			chk("gen", O_CLKGEN_ACTIVE, v[3:2] == 2'h0);
			rd(MA, v);
		end
		// Upper data bits must not leak into the 4-bit register
		repeat (6)
		begin
			lfsr = lfsr_next(lfsr);
			apb(1'b1, MA, lfsr);
			apb(1'b1, 12'h054, ~lfsr);
			rd(12'h054, 32'h0);
			rd(MA, lfsr[3:0]);
		end
		I_CE_RST <= 1'b1;
		repeat (6) @(posedge I_SYS_CLK);
		I_CE_RST <= 1'b0;
		repeat (4) @(posedge I_SYS_CLK);
		rd(MA, lfsr[3:0]);
		apb(1'b1, MA, 32'hf);
		I_CLK_STOP_RST <= 1'b1;
		repeat (6) @(posedge I_SYS_CLK);
		I_CLK_STOP_RST <= 1'b0;
		repeat (4) @(posedge I_SYS_CLK);
		rd(MA, 32'h0);
		apb(1'b1, MA, 32'h0);
		apb(1'b1, GA, 32'h1);
		rd(GA, 32'h1);
		route_req <= 1'b1;
		wait_pin(1'b1, 1'b1);
		// Pin may rise with the route itself: time a true toggle instead
		wait_pin(1'b0, 1'b0);
		wait_pin(1'b0, 1'b1);
		wait_pin(1'b0, 1'b0);
		chk("half period", n, 2 * `FCMS_BASE_DIV);
		apb(1'b1, MA, 32'h4);
		wait_pin(1'b1, 1'b0);
		end_of_test();
	end
endmodule // tb_freq_counter_clkgen_mode_select
